// file: rtl/sir_endec_pkg.sv
package sir_endec_pkg;

  // system clock and the emulated oscillator
  localparam longint SYS_CLK_HZ = 64'd200000000;
  localparam longint OSC_HZ     = 64'd3686400;
  localparam int     ACC_W      = 32;
  // phase increment per system clock, osc_hz * 2^32 / sys_clk_hz
  localparam logic [ACC_W-1:0] OSC_INC = ACC_W'((OSC_HZ << ACC_W) / SYS_CLK_HZ);

  // baud generation: 16 samples per bit, divisor counts oscillator ticks
  localparam int         RATE_COUNT   = 13;
  localparam int         RATE_W       = 4;
  localparam int         DIV_W        = 8;
  localparam int         PHASE_W      = 4;
  localparam logic [3:0] PHASE_LAST   = 4'hF;
  localparam logic [3:0] RATE_DEFAULT = 4'h6;
  localparam logic [3:0] RATE_MAX     = 4'hC;
  // index 0..12: 1200 1800 2400 3600 4800 7200 9600 14400 19200 28800 38400 57600 115200
  localparam logic [7:0] RATE_DIVISOR [0:12] = '{
    8'hC0, 8'h80, 8'h60, 8'h40, 8'h30, 8'h20, 8'h18,
    8'h10, 8'h0C, 8'h08, 8'h06, 8'h04, 8'h02
  };

  // transmit pulse widths
  localparam longint FIXED_PULSE_PS    = 64'd1627000;
  localparam int     PCNT_W            = 3;
  // nearest whole oscillator period to the fixed width
  localparam logic [2:0] FIXED_PULSE_TICKS =
    3'((FIXED_PULSE_PS * OSC_HZ + 64'd500000000000) / 64'd1000000000000);
  localparam logic [2:0] WIDE_PULSE_TICKS  = 3'h3;

  // control word layout
  localparam int   CW_W        = 8;
  localparam int   CW_RATE_LSB = 0;
  localparam int   CW_WIDE_BIT = 4;
  localparam logic WIDE_DEFAULT = 1'b0;

  // control character receiver
  localparam logic [3:0] HALF_BIT  = 4'h7;
  localparam logic [2:0] LAST_DBIT = 3'h7;

  localparam int FIFO_DEPTH = 32;

  typedef enum logic [4:0] {
    CW_IDLE  = 5'h01,
    CW_START = 5'h02,
    CW_DATA  = 5'h04,
    CW_STOP  = 5'h08,
    CW_HOLD  = 5'h10
  } cw_state_e;

endpackage

// file: rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,       // system clock
  input  wire logic             arst_n,    // async reset, active low
  input  wire logic             flush,     // empty the buffer
  input  wire logic [WIDTH-1:0] in_data,   // word to store
  input  wire logic             in_valid,  // in_data present
  output logic                  in_ready,  // room for a word
  output logic      [WIDTH-1:0] out_data,  // oldest word
  output logic                  out_valid, // out_data present
  input  wire logic             out_ready  // consumer takes word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  wire full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire push  = in_valid && !full && !flush;
  wire pop   = out_ready && !empty && !flush;

  assign in_ready  = !full && !flush;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// file: rtl/sir_pulse_endec.sv
// Behaviour
// R1: all pulse timing derives from one 3.6864 MHz oscillator tick; fixed width uses a second phase at that rate.
// R2: each active host transmit bit becomes one short optical pulse.
// R3: each received optical pulse is stretched to one full bit period.
// R4: pulse width is fixed 1.627 us or 3/16 bit, per control word.
// R5: thirteen bit rates from 1200 to 115200 bit/s chosen by control word.
// R6: reset input high clears all configuration state.
// R7: reset selects 9600 bit/s and fixed 1.627 us pulse.
// R8: transceiver shutdown output is always the inverted reset input.
// R9: oscillator held stopped during reset, runs again after release.
// R10: select low is data mode: encode transmit, decode receive.
// R11: select high takes host serial data as control word, not infrared.
// R12: new setting applies only once the select input returns low.
// R13: host receive output and host transmit input are active high.
// R14: optical transmit pulses are driven active high.
// R15: transceiver delivers active-low receive pulses of at least 1.63 us.
// R16: control word is one character at current rate; optical output idles.
`timescale 1ns/1ps
module sir_pulse_endec
  import sir_endec_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input  wire logic              clk,                      // system clock, 200 MHz
  input  wire logic              arst_n,                   // async reset, active low
  input  wire logic              reset_in,                 // device reset pin, active high
  input  wire logic              rate_program_select,      // high = programming mode
  input  wire logic              host_tx_in,               // host transmit data, active high
  output logic                   host_rx_out,              // stretched receive data, active high
  output logic                   optical_tx_out,           // shortened pulses, active high
  input  wire logic              optical_rx_in,            // transceiver pulses, active low
  output logic                   transceiver_shutdown_out, // inverted reset pin
  output logic                   osc_running,              // oscillator ticking
  output logic      [RATE_W-1:0] rate_index_out,           // active rate index
  output logic                   wide_pulse_out            // 1 = 3/16 bit pulse
);

  // configuration
  logic [RATE_W-1:0] rate_reg;
  logic              wide_reg;

  // oscillator and baud ticks
  logic [ACC_W-1:0]  acc_reg;
  logic [DIV_W-1:0]  div_cnt_reg;

  // encoder
  logic               tx_busy_reg;
  logic               tx_pulse_reg;
  logic [PHASE_W-1:0] tx_phase_reg;
  logic [PCNT_W-1:0]  tx_pcnt_reg;
  logic [ACC_W-1:0]   tx_acc_reg;

  // decoder
  logic               rx_prev_low_reg;
  logic               rx_out_reg;
  logic [PHASE_W-1:0] rx_phase_reg;

  // control word receiver
  cw_state_e          cw_state_reg;
  cw_state_e          cw_state_next;
  logic [PHASE_W-1:0] cw_phase_reg;
  logic [2:0]         cw_bit_reg;
  logic [CW_W-1:0]    cw_shift_reg;

  // fifo
  logic              fifo_in_ready;
  logic [CW_W-1:0]   fifo_out_data;
  logic              fifo_out_valid;

  // R8: shutdown follows inverted reset
  assign transceiver_shutdown_out = !reset_in;

  // R10: select low, data mode
  wire data_mode = !rate_program_select && !reset_in;
  wire prog_mode = rate_program_select && !reset_in;

  // R9: oscillator stopped while reset pin high
  // R1: osc_tick drives baud and stretch timing; fixed pulse width counts its own phase at the same rate
  wire [ACC_W:0] acc_sum   = {1'b0, acc_reg} + {1'b0, OSC_INC};
  wire           osc_tick  = acc_sum[ACC_W] && !reset_in;
  assign osc_running       = !reset_in;

  // R5: divisor picked by rate index
  wire [DIV_W-1:0] div_now  = RATE_DIVISOR[rate_reg];
  wire             div_wrap = (div_cnt_reg >= div_now - 1'b1);
  wire             b16_tick = osc_tick && div_wrap;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_reg     <= '0;
      div_cnt_reg <= '0;
    end
    else if (reset_in)
    begin
      acc_reg     <= '0;
      div_cnt_reg <= '0;
    end
    else
    begin
      acc_reg <= acc_sum[ACC_W-1:0];
      if (osc_tick)
      begin
        div_cnt_reg <= div_wrap ? '0 : div_cnt_reg + 1'b1;
      end
    end
  end

  // R4: pulse length counted in osc ticks or 16x ticks
  // own oscillator phase, restarted per pulse, so fixed width is whole periods
  wire [ACC_W:0]    tx_acc_sum  = {1'b0, tx_acc_reg} + {1'b0, OSC_INC};
  wire              pulse_tick  = wide_reg ? b16_tick : tx_acc_sum[ACC_W];
  wire [PCNT_W-1:0] pulse_limit = wide_reg ? WIDE_PULSE_TICKS : FIXED_PULSE_TICKS;
  wire              pulse_end   = tx_pulse_reg && pulse_tick && (tx_pcnt_reg == pulse_limit - 1'b1);
  wire              bit_end     = tx_busy_reg && b16_tick && (tx_phase_reg == PHASE_LAST);
  // R13: active bit is a high level on host_tx_in
  wire              tx_start    = host_tx_in && (!tx_busy_reg || bit_end);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_acc_reg   <= '0;
      tx_busy_reg  <= 1'b0;
      tx_pulse_reg <= 1'b0;
      tx_phase_reg <= '0;
      tx_pcnt_reg  <= '0;
    end
    else if (!data_mode)
    begin
      // R16: optical output idle outside data mode
      tx_acc_reg   <= '0;
      tx_busy_reg  <= 1'b0;
      tx_pulse_reg <= 1'b0;
      tx_phase_reg <= '0;
      tx_pcnt_reg  <= '0;
    end
    else if (tx_start)
    begin
      // R2: one pulse per active bit
      tx_acc_reg   <= '0;
      tx_busy_reg  <= 1'b1;
      tx_pulse_reg <= 1'b1;
      tx_phase_reg <= '0;
      tx_pcnt_reg  <= '0;
    end
    else
    begin
      tx_acc_reg <= tx_acc_sum[ACC_W-1:0];
      if (bit_end)
      begin
        tx_busy_reg <= 1'b0;
      end
      if (b16_tick)
      begin
        tx_phase_reg <= tx_phase_reg + 1'b1;
      end
      if (pulse_end)
      begin
        tx_pulse_reg <= 1'b0;
      end
      else if (tx_pulse_reg && pulse_tick)
      begin
        tx_pcnt_reg <= tx_pcnt_reg + 1'b1;
      end
    end
  end

  // R14: active-high optical pulse
  assign optical_tx_out = tx_pulse_reg;

  // R15: receive pulse is low on optical_rx_in
  wire rx_low  = !optical_rx_in;
  wire rx_edge = rx_low && !rx_prev_low_reg;
  wire rx_done = rx_out_reg && b16_tick && (rx_phase_reg == PHASE_LAST);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_prev_low_reg <= 1'b0;
      rx_out_reg      <= 1'b0;
      rx_phase_reg    <= '0;
    end
    else
    begin
      rx_prev_low_reg <= rx_low;
      if (!data_mode)
      begin
        rx_out_reg   <= 1'b0;
        rx_phase_reg <= '0;
      end
      else if (rx_edge)
      begin
        // R3: stretch to one bit period
        rx_out_reg   <= 1'b1;
        rx_phase_reg <= '0;
      end
      else if (rx_done)
      begin
        rx_out_reg <= 1'b0;
      end
      else if (rx_out_reg && b16_tick)
      begin
        rx_phase_reg <= rx_phase_reg + 1'b1;
      end
    end
  end

  // R13: stretched data active high
  assign host_rx_out = rx_out_reg;

  // R11: host serial data read as control word in programming mode
  // R16: one character at the active rate, start bit high
  wire cw_mid   = b16_tick && (cw_phase_reg == HALF_BIT);
  wire cw_full  = b16_tick && (cw_phase_reg == PHASE_LAST);
  wire cw_valid = (cw_state_reg == CW_HOLD);
  wire cw_push  = cw_valid && fifo_in_ready;

  always_comb
  begin
    cw_state_next = cw_state_reg;
    case (cw_state_reg)
      CW_IDLE:
      begin
        if (prog_mode && host_tx_in)
        begin
          cw_state_next = CW_START;
        end
      end
      CW_START:
      begin
        if (cw_mid)
        begin
          cw_state_next = host_tx_in ? CW_DATA : CW_IDLE;
        end
      end
      CW_DATA:
      begin
        if (cw_full && (cw_bit_reg == LAST_DBIT))
        begin
          cw_state_next = CW_STOP;
        end
      end
      CW_STOP:
      begin
        if (cw_full)
        begin
          cw_state_next = host_tx_in ? CW_IDLE : CW_HOLD;
        end
      end
      CW_HOLD:
      begin
        if (cw_push)
        begin
          cw_state_next = CW_IDLE;
        end
      end
      default:
      begin
        cw_state_next = CW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cw_state_reg <= CW_IDLE;
      cw_phase_reg <= '0;
      cw_bit_reg   <= '0;
      cw_shift_reg <= '0;
    end
    // pin reset also drops a held word
    else if (reset_in || (!prog_mode && !cw_valid))
    begin
      cw_state_reg <= CW_IDLE;
      cw_phase_reg <= '0;
      cw_bit_reg   <= '0;
    end
    else
    begin
      cw_state_reg <= cw_state_next;
      if (cw_state_reg == CW_IDLE)
      begin
        cw_phase_reg <= '0;
        cw_bit_reg   <= '0;
      end
      else if (cw_mid && (cw_state_reg == CW_START))
      begin
        cw_phase_reg <= '0;
      end
      else if (b16_tick)
      begin
        cw_phase_reg <= cw_phase_reg + 1'b1;
      end
      // sample at bit centre; active level means a zero bit
      if (cw_full && (cw_state_reg == CW_DATA))
      begin
        cw_shift_reg <= {!host_tx_in, cw_shift_reg[CW_W-1:1]};
        cw_bit_reg   <= cw_bit_reg + 1'b1;
      end
    end
  end

  // R12: stored words drain only when select is low
  wire fifo_pop = fifo_out_valid && data_mode;

  word_fifo #(
    .WIDTH (CW_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_cw_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .flush     (reset_in),
    .in_data   (cw_shift_reg),
    .in_valid  (cw_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (data_mode)
  );

  wire [RATE_W-1:0] word_rate = fifo_out_data[CW_RATE_LSB +: RATE_W];
  wire              rate_ok   = (word_rate <= RATE_MAX);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_reg <= RATE_DEFAULT;
      wide_reg <= WIDE_DEFAULT;
    end
    // R6: reset pin clears configuration
    // R7: defaults 9600 bit/s, fixed pulse
    else if (reset_in)
    begin
      rate_reg <= RATE_DEFAULT;
      wide_reg <= WIDE_DEFAULT;
    end
    // R12: apply after select returns low
    else if (fifo_pop)
    begin
      if (rate_ok)
      begin
        rate_reg <= word_rate;
      end
      wide_reg <= fifo_out_data[CW_WIDE_BIT];
    end
  end

  assign rate_index_out = rate_reg;
  assign wide_pulse_out = wide_reg;

endmodule

// file: verification/sir_pulse_endec_sva.sv
`timescale 1ns/1ps
module sir_pulse_endec_sva
  import sir_endec_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic              clk,                      // clock
  input wire logic              arst_n,                   // reset
  input wire logic              reset_in,                 // pin reset
  input wire logic              rate_program_select,      // mode
  input wire logic              host_tx_in,               // host data
  input wire logic              host_rx_out,              // stretched
  input wire logic              optical_tx_out,           // pulses
  input wire logic              optical_rx_in,            // optical in
  input wire logic              transceiver_shutdown_out, // shutdown
  input wire logic              osc_running,              // oscillator
  input wire logic [RATE_W-1:0] rate_index_out,           // rate
  input wire logic              wide_pulse_out            // width
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_sd_inverse: assert property (transceiver_shutdown_out == !reset_in)
    else $error("shutdown not inverted reset");
  chk_osc_stop: assert property (osc_running == !reset_in)
    else $error("oscillator state wrong");
  chk_reset_dflt: assert property (reset_in |=> rate_index_out == RATE_DEFAULT && !wide_pulse_out)
    else $error("reset defaults missing");
  chk_cfg_held: assert property (rate_program_select && !reset_in
    |=> $stable(rate_index_out) && $stable(wide_pulse_out))
    else $error("setting changed while programming");
  chk_rate_range: assert property (rate_index_out <= RATE_MAX)
    else $error("rate index out of range");
  chk_tx_cause: assert property ($rose(optical_tx_out) |-> $past(host_tx_in))
    else $error("pulse without host bit");
  chk_tx_prog_idle: assert property (rate_program_select && $past(rate_program_select) |-> !optical_tx_out)
    else $error("optical output active while programming");
  chk_rx_stretch: assert property ($fell(optical_rx_in) && !rate_program_select && !reset_in |=> host_rx_out)
    else $error("receive pulse not stretched");
  chk_rx_prog_low: assert property (rate_program_select && $past(rate_program_select) |-> !host_rx_out)
    else $error("receive output active while programming");
endmodule

bind sir_pulse_endec sir_pulse_endec_sva #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) chk (
  .clk, .arst_n, .reset_in, .rate_program_select, .host_tx_in, .host_rx_out, .optical_tx_out,
  .optical_rx_in, .transceiver_shutdown_out, .osc_running, .rate_index_out, .wide_pulse_out
);

// file: verification/sir_far_side.sv
`timescale 1ns/1ps
module sir_far_side (
  input  wire logic clk,           // clock
  output logic      host_tx_in,    // host data
  output logic      optical_rx_in  // optical in
);
  initial
  begin
    host_tx_in = 1'b0;
    optical_rx_in = 1'b1;
  end

  task automatic send_char(input logic [7:0] w, input int bclk);
    logic [9:0] f;
    f = {1'b0, ~w, 1'b1};
    for (int i = 0; i < 10; i++)
    begin
      host_tx_in <= f[i];
      repeat (bclk) @(posedge clk);
    end
  endtask

  task automatic tx_bit();
    host_tx_in <= 1'b1;
    @(posedge clk);
    host_tx_in <= 1'b0;
  endtask

  task automatic pulse(input int w);
    optical_rx_in <= 1'b0;
    repeat (w) @(posedge clk);
    optical_rx_in <= 1'b1;
  endtask
endmodule

// file: verification/sir_pulse_endec_tb.sv
`timescale 1ns/1ps
module sir_pulse_endec_tb
  import sir_endec_pkg::*;
;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              reset_in = 1'b1;
  logic              sel = 1'b0;
  logic              host_tx_in;
  logic              optical_rx_in;
  logic              host_rx_out;
  logic              optical_tx_out;
  logic              shutdown;
  logic              osc_running;
  logic [RATE_W-1:0] rate;
  logic              wide;
  logic [16:0]       rnd = 17'h14612;
  int                failures = 0;
  int                comparisons = 0;
  int                exp_rate = RATE_DEFAULT;
  int                exp_wide = 0;
  int                pend[$];

  always #2.5 clk = ~clk;

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  sir_pulse_endec uut (
    .clk(clk), .arst_n(arst_n), .reset_in(reset_in), .rate_program_select(sel),
    .host_tx_in(host_tx_in), .host_rx_out(host_rx_out), .optical_tx_out(optical_tx_out),
    .optical_rx_in(optical_rx_in), .transceiver_shutdown_out(shutdown),
    .osc_running(osc_running), .rate_index_out(rate), .wide_pulse_out(wide)
  );

  sir_far_side far (
    .clk(clk), .host_tx_in(host_tx_in), .optical_rx_in(optical_rx_in)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic range(input string what, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic check_cfg();
    @(negedge clk);
    check("rate", exp_rate, 32'(rate));
    check("wide", exp_wide, 32'(wide));
    @(posedge clk);
  endtask

  // widths counted at negedge, away from updates
  task automatic check_all(input string name);
    int d;
    int n;
    d = RATE_DIVISOR[exp_rate];
    check_cfg();
    n = 0;
    far.tx_bit();
    repeat (800)
    begin
      @(negedge clk);
      if (optical_tx_out === 1'b1) n++;
    end
    if (exp_wide == 1)
      range("wide pulse", 2 * d * 54, 3 * d * 55 + 2, n);
    else
      range("fixed pulse", 318, 334, n);
    @(posedge clk);
    repeat (rnd[4:0]) @(posedge clk);
    rnd = lfsr_next(rnd);
    n = 0;
    fork
      far.pulse(330 + rnd[5:0]);
    join_none
    repeat (16 * d * 55 + 400)
    begin
      @(negedge clk);
      if (host_rx_out === 1'b1) n++;
    end
    range("stretch", 15 * d * 54, 16 * d * 55 + 2, n);
    @(posedge clk);
    $display("done: %s", name);
  endtask

  // bad rate kept, width still taken, last wins
  task automatic apply();
    int w;
    while (pend.size() > 0)
    begin
      w = pend.pop_front();
      if (w % 16 <= 12) exp_rate = w % 16;
      exp_wide = (w / 16) % 2;
    end
  endtask

  task automatic prog(input logic [7:0] a, input logic [7:0] b, input int n);
    int bclk;
    bclk = RATE_DIVISOR[exp_rate] * 868;
    sel <= 1'b1;
    @(posedge clk);
    far.send_char(a, bclk);
    pend.push_back(a);
    if (n > 1)
    begin
      far.send_char(b, bclk);
      pend.push_back(b);
    end
    check_cfg();
    sel <= 1'b0;
    repeat (8) @(posedge clk);
    apply();
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reset_in <= 1'b0;
    @(posedge clk);
    check_all("defaults");
    prog(8'h1C, 8'h00, 1);
    check_all("wide pulse");
    prog(8'h0B, 8'h1F, 2);
    check_all("two words");
    reset_in <= 1'b1;
    pend.delete();
    exp_rate = RATE_DEFAULT;
    exp_wide = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("shutdown", 0, 32'(shutdown));
    check("osc", 0, 32'(osc_running));
    @(posedge clk);
    reset_in <= 1'b0;
    check_cfg();
    check("shutdown", 1, 32'(shutdown));
    check("osc", 1, 32'(osc_running));
    $display("done: device reset");
    end_sim();
  end

  // whole run is near 275k cycles
  initial
  begin
    #3000000;
    failures++;
    end_sim();
  end
endmodule
